// *** pkg/sar_readout_pkg.sv ***
// ----------------------------------------------------------------------------
// Shared constants for the converter sequencing and serial readout.
// ----------------------------------------------------------------------------
package sar_readout_pkg;

    // Width of the conversion result.
    localparam int RESULT_W = 12;

    // Bit positions of the result ends and of the first resent bit.
    localparam logic [3:0] RESULT_MSB_IDX = 4'hB;
    localparam logic [3:0] RESULT_LSB_IDX = 4'h0;
    localparam logic [3:0] REVERSE_FIRST_IDX = 4'h1;

    // Straight binary codes of interest.
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MIDSCALE = 12'h800;
    localparam logic [11:0] CODE_FULL = 12'hFFF;

    // Falling data clock edge, counted from chip select low, that ends sampling.
    localparam logic [1:0] NULL_EDGE = 2'h2;
    localparam logic [1:0] EDGE_ONE = 2'h1;

    // Sample window in data clock periods, tenths.
    localparam int SAMPLE_MIN_TENTHS = 15;
    localparam int SAMPLE_MAX_TENTHS = 20;

    // Value driven during the null bit.
    localparam logic NULL_LEVEL = 1'b0;

    // Depth of the pin synchroniser.
    localparam int SYNC_DEPTH = 3;

    // Sequencer states.
    typedef enum logic [2:0] {
        st_shutdown,
        st_sample,
        st_convert,
        st_reverse,
        st_tail,
        st_finished
    } seq_state_t;

endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter and edge pulses.
// ----------------------------------------------------------------------------
module pin_sync
    import sar_readout_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Asynchronous pin.
    input wire logic pin,
    // Filtered level and one-cycle edge pulses.
    output logic level,
    output logic fall,
    output logic rise
);

    logic [SYNC_DEPTH-1:0] stage;
    logic agree;
    logic next_level;

    // Stages two and three must agree before the level moves.
    assign agree = (stage[1] == stage[2]);
    assign next_level = agree ? stage[2] : level;

    // Shift chain; the first stage feeds only the second.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage <= {SYNC_DEPTH{RESET_LEVEL}};
        end else if (clk_en) begin
            stage <= {stage[SYNC_DEPTH-2:0], pin};
        end
    end

    // Filtered level and edge pulses.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level <= RESET_LEVEL;
            fall <= 1'b0;
            rise <= 1'b0;
        end else if (clk_en) begin
            level <= next_level;
            fall <= level & ~next_level;
            rise <= ~level & next_level;
        end
    end

endmodule

`default_nettype wire

// *** logic/sar_adc_serial_readout.sv ***
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Chip select falling starts conversion and transfer.
// - Sample input for first 1.5-2 clocks.
// - Second falling edge: enable output, null low.
// - Next twelve periods shift result, MSB first.
// - After LSB, resend result LSB first.
// - After MSB repeated, output goes high impedance.
// - Later clocks change nothing while selected.
// - New conversion needs chip select high then low.
// - Output bits change on data clock falling edge.
// - Result is unsigned straight binary code.
// - Bits belong to current conversion, no latency.
// - Chip select high means full shutdown.
// - Raising chip select aborts at any bit.
// - Analog section powers down after conversion ends.

module sar_adc_serial_readout
    import sar_readout_pkg::*;
(
    // System clock, reset and enable.
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Serial link pins.
    input wire logic select_n_shutdown,
    input wire logic conversion_shift_clk,
    output logic data_out,
    output logic data_out_en,
    // Analog section control.
    input wire logic comparator_above,
    output logic [RESULT_W-1:0] dac_trial,
    output logic sample_hold,
    output logic analog_active,
    // Sequencer status.
    output logic digital_active
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------

    logic sel_level;
    logic sel_fall;
    logic dclk_fall;

    // Chip select, idle high so that a low pin at reset release still counts as a fall.
    pin_sync #(
        .RESET_LEVEL(1'b1)
    ) u_sel_sync (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin(select_n_shutdown),
        .level(sel_level),
        .fall(sel_fall),
        .rise()
    );

    // Data clock from the host.
    pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_dclk_sync (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin(conversion_shift_clk),
        .level(),
        .fall(dclk_fall),
        .rise()
    );

    // ------------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------------

    seq_state_t state;
    seq_state_t next_state;
    logic [1:0] edge_count;
    logic [3:0] bit_idx;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] trial_bit;
    logic [RESULT_W-1:0] lower_bit;
    logic [RESULT_W-1:0] next_result;
    logic [RESULT_W-1:0] next_trial;
    logic decision;
    logic reverse_bit;
    logic at_null_edge;
    logic at_lsb;
    logic at_msb;
    logic step;

    // Decode helpers for the current bit position.
    assign trial_bit = RESULT_W'(1) << bit_idx;
    assign lower_bit = trial_bit >> 1;
    assign at_null_edge = (edge_count == (NULL_EDGE - EDGE_ONE));
    assign at_lsb = (bit_idx == RESULT_LSB_IDX);
    assign at_msb = (bit_idx == RESULT_MSB_IDX);
    assign step = dclk_fall & ~sel_level;

    // Decision emitted live
    // The bit decided at this edge is the bit sent at this edge.
    assign decision = comparator_above;
    assign reverse_bit = result[bit_idx];

    // Straight binary weighting
    // Keep or drop the trial bit, then try the next lower one.
    assign next_result = decision ? (result | trial_bit) : result;
    assign next_trial = (decision ? dac_trial : (dac_trial & ~trial_bit)) | lower_bit;

    // State transitions.
    always_comb begin
        next_state = state;
        case (state)
            st_shutdown: begin
                if (sel_fall) begin
                    next_state = st_sample;
                end
            end
            st_sample: begin
                if (step && at_null_edge) begin
                    next_state = st_convert;
                end
            end
            st_convert: begin
                if (step && at_lsb) begin
                    next_state = st_reverse;
                end
            end
            st_reverse: begin
                if (step && at_msb) begin
                    next_state = st_tail;
                end
            end
            st_tail: begin
                if (step) begin
                    next_state = st_finished;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
        if (sel_level) begin
            next_state = st_shutdown;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= st_shutdown;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Sample window count
    // Counts falling edges from select low up to the null edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            edge_count <= 2'h0;
        end else if (clk_en) begin
            if (state != st_sample) begin
                edge_count <= 2'h0;
            end else if (step) begin
                edge_count <= edge_count + EDGE_ONE;
            end
        end
    end

    // Bit index walk
    // Down from the top during conversion, up again for the reversed copy.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_idx <= RESULT_MSB_IDX;
        end else if (clk_en) begin
            if (state == st_shutdown) begin
                bit_idx <= RESULT_MSB_IDX;
            end else if (step && state == st_convert) begin
                bit_idx <= at_lsb ? REVERSE_FIRST_IDX : bit_idx - 4'h1;
            end else if (step && state == st_reverse && !at_msb) begin
                bit_idx <= bit_idx + 4'h1;
            end
        end
    end

    // Successive approximation register and trial code.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result <= CODE_ZERO;
            dac_trial <= CODE_ZERO;
        end else if (clk_en) begin
            if (state == st_shutdown && sel_fall) begin
                result <= CODE_ZERO;
                dac_trial <= CODE_MIDSCALE;
            end else if (step && state == st_convert) begin
                result <= next_result;
                dac_trial <= next_trial;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------------

    // Output data and its enable change on data clock falls, and clear when chip select goes high.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_out <= NULL_LEVEL;
            data_out_en <= 1'b0;
        end else if (clk_en) begin
            if (sel_level) begin
                data_out_en <= 1'b0;
                data_out <= NULL_LEVEL;
            end else if (step) begin
                case (state)
                    st_sample: begin
                        if (at_null_edge) begin
                            data_out_en <= 1'b1;
                            data_out <= NULL_LEVEL;
                        end
                    end
                    st_convert: begin
                        data_out <= decision;
                    end
                    st_reverse: begin
                        data_out <= reverse_bit;
                    end
                    st_tail: begin
                        data_out_en <= 1'b0;
                        data_out <= NULL_LEVEL;
                    end
                    default: begin
                        data_out_en <= data_out_en;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Power and sampling status
    // ------------------------------------------------------------------------

    // Analog idle after conversion
    // Analog side runs from select low until the last decision.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_hold <= 1'b0;
            analog_active <= 1'b0;
            digital_active <= 1'b0;
        end else if (clk_en) begin
            sample_hold <= (next_state == st_sample);
            analog_active <= (next_state == st_sample) || (next_state == st_convert);
            digital_active <= (next_state != st_shutdown);
        end
    end

endmodule

`default_nettype wire

// *** tb/sar_readout_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// Pin protocol checks.
// ----
module sar_readout_asserts
    import sar_readout_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Link pins.
    input wire logic select_n_shutdown,
    input wire logic conversion_shift_clk,
    input wire logic data_out,
    input wire logic data_out_en,
    // Analog and status.
    input wire logic comparator_above,
    input wire logic [RESULT_W-1:0] dac_trial,
    input wire logic sample_hold,
    input wire logic analog_active,
    input wire logic digital_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [1:0] frames;
    // Counts output enables within one selected period.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frames <= 2'h0;
        end else if (select_n_shutdown) begin
            frames <= 2'h0;
        end else if ($rose(data_out_en)) begin
            frames <= frames + 2'h1;
        end
    end
    sel_shutdown_a: assert property (select_n_shutdown [*8] |-> !digital_active && !analog_active)
        else $error("active while deselected");
    abort_release_a: assert property ($rose(select_n_shutdown) |-> ##[1:6] !data_out_en)
        else $error("output kept after deselect");
    bit_timing_a: assert property ($changed(data_out) && data_out_en |->
        !$past(conversion_shift_clk, 3) && $past(conversion_shift_clk, 7))
        else $error("data changed off a falling clock");
    null_low_a: assert property ($rose(data_out_en) |-> !data_out)
        else $error("null bit not low");
    sample_end_a: assert property ($fell(sample_hold) && !select_n_shutdown |-> $rose(data_out_en))
        else $error("sampling ended off the null edge");
    one_frame_a: assert property (frames < 2'h2)
        else $error("second frame without deselect");
    analog_done_a: assert property ($fell(analog_active) && !select_n_shutdown |-> data_out_en && digital_active)
        else $error("analog stopped at wrong time");
    dac_start_a: assert property ($rose(sample_hold) |-> dac_trial == CODE_MIDSCALE && analog_active)
        else $error("first trial not midscale");
    full_cover: cover property ($fell(data_out_en) && !select_n_shutdown);
    abort_cover: cover property ($rose(select_n_shutdown) && data_out_en);
    analog_cover: cover property ($fell(analog_active));
endmodule
bind sar_adc_serial_readout sar_readout_asserts sar_readout_asserts_i (.clk(clk), .resetn(resetn),
    .clk_en(clk_en), .select_n_shutdown(select_n_shutdown), .conversion_shift_clk(conversion_shift_clk),
    .data_out(data_out), .data_out_en(data_out_en), .comparator_above(comparator_above),
    .dac_trial(dac_trial), .sample_hold(sample_hold), .analog_active(analog_active),
    .digital_active(digital_active));
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// Host receiver: selects, clocks and captures one frame.
// ----
module host_model (
    // Clock and request.
    input wire logic clk,
    input wire logic go,
    input wire logic [4:0] falls,
    // Link pins.
    output logic select_n_shutdown,
    output logic conversion_shift_clk,
    input wire logic data_out,
    input wire logic data_out_en,
    // Captured bits, last rise in bit 0.
    output logic busy,
    output logic [31:0] rx,
    output logic [31:0] rx_en
);
    // Half data clock period of 42 system clocks, 420 ns, so the clock stays under 1.2 MHz.
    localparam logic [5:0] HALF_LAST = 6'h29;
    logic [5:0] t = 6'h0;
    logic [5:0] n = 6'h0;
    logic held = 1'b0;
    // Deselected and idle at start.
    initial begin
        select_n_shutdown = 1'b1;
        conversion_shift_clk = 1'b0;
        busy = 1'b0;
    end
    // Data clock halves last 42 system clocks; the clock rests low outside frames.
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            select_n_shutdown <= 1'b0;
            t <= 6'h0;
            n <= 6'h0;
        end else if (busy) begin
            t <= t + 6'h1;
            if (t == HALF_LAST) begin
                t <= 6'h0;
                if (n < {falls, 1'b0}) begin
                    conversion_shift_clk <= ~conversion_shift_clk;
                    n <= n + 6'h1;
                    if (!conversion_shift_clk) begin
                        rx <= {rx[30:0], data_out};
                        rx_en <= {rx_en[30:0], data_out_en};
                    end
                end else if (!select_n_shutdown) begin
                    select_n_shutdown <= 1'b1;
                    held <= 1'b0;
                // deselect for one full clock period
                end else if (!held) begin
                    held <= 1'b1;
                end else begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/test_sar_adc_serial_readout.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// Self-checking bench for the serial readout.
// ----
module test_sar_adc_serial_readout
    import sar_readout_pkg::*;
;
    `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic comparator_above = 1'b0;
    logic go = 1'b0;
    logic [4:0] falls = 5'h0;
    logic [11:0] target = 12'h000;
    logic select_n_shutdown, conversion_shift_clk, data_out, data_out_en, busy;
    logic sample_hold, analog_active, digital_active;
    logic [RESULT_W-1:0] dac_trial;
    logic [31:0] rx, rx_en;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // Clock and hang limit.
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            test_done();
        end
    end
    // Comparator of an ideal input equal to the target code.
    always @(posedge clk) comparator_above <= target >= dac_trial;
    sar_adc_serial_readout sar_adc_serial_readout_i (.clk(clk), .resetn(resetn), .clk_en(1'b1),
        .select_n_shutdown(select_n_shutdown), .conversion_shift_clk(conversion_shift_clk),
        .data_out(data_out), .data_out_en(data_out_en), .comparator_above(comparator_above),
        .dac_trial(dac_trial), .sample_hold(sample_hold), .analog_active(analog_active),
        .digital_active(digital_active));
    host_model host_model_i (.clk(clk), .go(go), .falls(falls), .select_n_shutdown(select_n_shutdown),
        .conversion_shift_clk(conversion_shift_clk), .data_out(data_out), .data_out_en(data_out_en),
        .busy(busy), .rx(rx), .rx_en(rx_en));
    // Prints the counts and the verdict.
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Runs one host frame with the given code and falling edge count.
    task automatic frame(input logic [11:0] code, input logic [4:0] n);
        @(posedge clk);
        target <= code;
        falls <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (4000) begin
            @(negedge clk);
            if (!busy) break;
        end
        `CHK(busy, 1'b0)
    endtask
    // Outputs idle after reset.
    task automatic t_reset();
        @(negedge clk);
        `CHK(data_out_en, 1'b0)
        `CHK(digital_active, 1'b0)
        `CHK(dac_trial, CODE_ZERO)
    endtask
    // Full frames, back to back, over the format codes.
    task automatic t_codes();
        logic [11:0] codes [5];
        logic [10:0] rev;
        codes = '{CODE_ZERO, CODE_MIDSCALE, 12'h7FF, CODE_FULL, 12'hA5C};
        foreach (codes[i]) begin
            frame(codes[i], 5'h1E);
            // The resend runs from bit one up to the top bit, so the last captured bit is the top one.
            for (int b = 0; b < 11; b++) begin
                rev[b] = codes[i][11 - b];
            end
            `CHK(rx[27], NULL_LEVEL)
            `CHK(rx[26:15], codes[i])
            `CHK(rx[14:4], rev)
            `CHK(rx_en[28:4], 25'h0FFFFFF)
            `CHK(rx_en[3:0], 4'h0)
        end
    endtask
    // Short cycle after the eighth result bit, of which the first seven are captured.
    task automatic t_abort();
        frame(12'h5A3, 5'h0A);
        `CHK(rx[7], NULL_LEVEL)
        `CHK(rx[6:0], 7'h2D)
        `CHK(data_out_en, 1'b0)
        `CHK(digital_active, 1'b0)
        `CHK(analog_active, 1'b0)
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_codes();
        t_abort();
        test_done();
    end
endmodule
`default_nettype wire
